// File: shared/mqp_pkg.sv
// constants, types and helpers for the queue and power register bank
// Overview of operation
// - power control two bit 7 lets the queue run in accel low-power mode, reset 0
// - power control two bits 5,4,3 switch off accel x, y, z when one
// - power control two bits 2,1,0 switch off gyro x, y, z when one
// - byte count is 13 bits: high register bits 4:0, low register bits 7:0
// - reading the high count register snapshots the whole count for both bytes
// - data port 0x74 reads the next queued byte, writes push a byte
// - each sample tick pushes enabled sensor bytes 59 to 72 in ascending order
// - a sensor group is queued only while its source enable flag is one
// - overflow sets the sticky overrun flag automatically
// - overflow drops the oldest bytes unless stop-on-full is set
// - empty queue reads return 0xff; real queued data never equal 0xff
// - read-only 8-bit identity register at 0x75 returns a fixed code
// - bus target address is 0x68 or 0x69 from the address-select pin
// - 15-bit two's complement accel trims: 14:7 in high, 6:0 in low 7:1
// - trims span plus minus 16g in 0.98 mg steps at every full scale
// - queue reset clears the queue at once; busy follows the request one cycle later for as long as it stays high
// - queue enable zero blocks serial access to the queue, sample-tick pushes unaffected
package mqp_pkg;
    localparam logic [7:0] OFS_PWR2 = 8'h6c;
    localparam logic [7:0] OFS_CNT_H = 8'h72;
    localparam logic [7:0] OFS_CNT_L = 8'h73;
    localparam logic [7:0] OFS_DATA = 8'h74;
    localparam logic [7:0] OFS_ID = 8'h75;
    // x high, x low, y high, y low, z high, z low
    localparam logic [7:0] OFS_TRIM [6] = '{8'h77, 8'h78, 8'h7a, 8'h7b, 8'h7d, 8'h7e};
    localparam int LP_ALLOW_BIT = 7;
    localparam int ACC_X_BIT = 5;
    localparam int ACC_Y_BIT = 4;
    localparam int ACC_Z_BIT = 3;
    localparam int GYR_X_BIT = 2;
    localparam int GYR_Y_BIT = 1;
    localparam int GYR_Z_BIT = 0;
    localparam logic [7:0] PWR2_RST = 8'h00;
    localparam logic [7:0] TRIM_H_RST = 8'h00;
    localparam logic [7:0] TRIM_L_RST = 8'h01;
    localparam logic [7:0] EMPTY_BYTE = 8'hff;
    localparam logic [7:0] CLAMP_BYTE = 8'hfe;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    localparam int QAW = 12;
    localparam int QDEPTH = 4096;
    localparam int CNT_W = 13;
    localparam logic [12:0] QCAP = 13'h1000;
    localparam logic [6:0] BUS_ADDR_BASE = 7'h68;
    localparam int SRC_BYTES = 14;
    localparam logic [3:0] SRC_LAST = 4'hd;
    localparam int GRP_W = 5;
    localparam int RD_LATENCY = 2;

    typedef enum logic [0:0] {MQP_IDLE = 1'b0, MQP_WALK = 1'b1} mqp_walk_t;

    // byte 0..5 accel, 6..7 temp, 8..9 gyro x, 10..11 gyro y, 12..13 gyro z
    function automatic logic [2:0] mqp_src_group(input logic [3:0] idx);
        if (idx < 4'd6) begin
            return 3'd0;
        end else if (idx < 4'd8) begin
            return 3'd1;
        end
        return 3'(4'd2 + ((idx - 4'd8) >> 1));
    endfunction
endpackage

// File: logic/mqp_queue_ram.sv
// byte memory of the sample queue with registered read data
`timescale 1ns/1ps
module mqp_queue_ram (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [mqp_pkg::QAW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic rd_en,
    input wire logic [mqp_pkg::QAW-1:0] raddr,
    output logic [7:0] rdata_q
);
    logic [7:0] mem [mqp_pkg::QDEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rd_en) begin
            rdata_q <= mem[raddr];
        end
    end
endmodule // mqp_queue_ram

// File: logic/mqp_sample_walker.sv
// walks the sensor output bytes after each sample tick and offers them to the queue
`timescale 1ns/1ps
module mqp_sample_walker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sample_tick,
    input wire logic [8*mqp_pkg::SRC_BYTES-1:0] sensor_bytes,
    input wire logic [mqp_pkg::GRP_W-1:0] src_enable,
    input wire logic push_allow,
    input wire logic push_ready,
    output logic push_valid,
    output logic [7:0] push_byte
);
    mqp_pkg::mqp_walk_t state_q, state_d;
    logic [3:0] idx_q, idx_d;
    logic [2:0] grp;
    logic [6:0] sel_base;
    logic grp_on;
    logic advance;

    assign grp = mqp_pkg::mqp_src_group(idx_q);
    assign grp_on = src_enable[grp] && push_allow;
    // byte index 0 is the lowest register number and sits in the top byte
    assign sel_base = {mqp_pkg::SRC_LAST - idx_q, 3'b000};
    assign push_byte = sensor_bytes[sel_base +: 8];
    assign push_valid = (state_q == mqp_pkg::MQP_WALK) && grp_on;
    assign advance = (state_q == mqp_pkg::MQP_WALK) && (!grp_on || push_ready);

    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            mqp_pkg::MQP_IDLE: begin
                if (sample_tick) begin
                    state_d = mqp_pkg::MQP_WALK;
                    idx_d = 4'h0;
                end
            end
            mqp_pkg::MQP_WALK: begin
                if (advance) begin
                    if (idx_q == mqp_pkg::SRC_LAST) begin
                        state_d = mqp_pkg::MQP_IDLE;
                    end else begin
                        idx_d = idx_q + 4'h1;
                    end
                end
            end
            default: begin
                state_d = mqp_pkg::MQP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= mqp_pkg::MQP_IDLE;
            idx_q <= 4'h0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    chk_walk_order: assert property (advance && idx_q != mqp_pkg::SRC_LAST |=> idx_q == $past(idx_q) + 4'h1)
        else $error("walker skipped or repeated a sensor byte");
    chk_group_gate: assert property (push_valid |-> src_enable[mqp_pkg::mqp_src_group(idx_q)])
        else $error("disabled sensor group offered to the queue");
endmodule // mqp_sample_walker

// File: logic/mqp_regs.sv
// queue, power control two, identity and accel trim registers of the motion sensor map
`timescale 1ns/1ps
module mqp_regs #(
    parameter logic [7:0] IDENTITY_VALUE = 8'h5a // arbitrary code
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sample_tick,
    input wire logic [8*mqp_pkg::SRC_BYTES-1:0] sensor_bytes,
    input wire logic [mqp_pkg::GRP_W-1:0] src_enable,
    input wire logic queue_enable,
    input wire logic stop_on_full,
    input wire logic accel_lowpower_mode,
    input wire logic queue_reset_req,
    input wire logic overrun_clear,
    input wire logic address_select_pin,
    output logic queue_lowpower_allow,
    output logic accel_x_off,
    output logic accel_y_off,
    output logic accel_z_off,
    output logic gyro_x_off,
    output logic gyro_y_off,
    output logic gyro_z_off,
    output logic queue_overrun_flag,
    output logic queue_reset_busy,
    output logic [6:0] bus_target_addr,
    output logic [14:0] accel_x_trim,
    output logic [14:0] accel_y_trim,
    output logic [14:0] accel_z_trim
);
    logic [7:0] pwr2_q;
    logic [7:0] trim_q [6];
    logic [12:0] count_q, count_d;
    logic [12:0] snap_q;
    logic [11:0] wr_ptr_q, rd_ptr_q;
    logic overrun_q;
    logic rst_busy_q;
    logic rd_stage_q, rd_pop_q;
    logic [7:0] rd_addr_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic sel_s0_q, sel_s1_q, sel_s2_q;
    logic [6:0] bus_addr_q;
    logic [7:0] ram_dout;

    // decode
    logic hit_pwr2, hit_cnt_h, hit_data;
    assign hit_pwr2 = reg_addr == mqp_pkg::OFS_PWR2;
    assign hit_cnt_h = reg_addr == mqp_pkg::OFS_CNT_H;
    assign hit_data = reg_addr == mqp_pkg::OFS_DATA;

    // queue traffic
    logic empty, full, host_pop, host_push, walk_valid, walk_ready, sens_push;
    logic push, drop, overwrite, do_write, cnt_inc, overflow_evt, push_allow;
    logic [7:0] walk_byte, raw_byte, wbyte;
    assign empty = count_q == 13'h0000;
    assign full = count_q == mqp_pkg::QCAP;
    assign host_pop = reg_rd && hit_data && queue_enable && !empty && !rst_busy_q;
    assign host_push = reg_wr && hit_data && queue_enable && !rst_busy_q;
    assign walk_ready = !host_push;
    assign push_allow = !accel_lowpower_mode || pwr2_q[mqp_pkg::LP_ALLOW_BIT];
    assign sens_push = walk_valid && walk_ready && !rst_busy_q;
    assign push = host_push || sens_push;
    assign raw_byte = host_push ? reg_wdata : walk_byte;
    assign wbyte = (raw_byte == mqp_pkg::EMPTY_BYTE) ? mqp_pkg::CLAMP_BYTE : raw_byte;
    // a pop in the same cycle makes room, so no overflow then
    assign overflow_evt = push && full && !host_pop;
    assign drop = overflow_evt && stop_on_full;
    assign overwrite = overflow_evt && !stop_on_full;
    assign do_write = push && !drop;
    assign cnt_inc = do_write && !overwrite;
    assign count_d = count_q + {12'h000, cnt_inc} - {12'h000, host_pop};

    mqp_sample_walker u_walker (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sample_tick(sample_tick),
        .sensor_bytes(sensor_bytes),
        .src_enable(src_enable),
        .push_allow(push_allow),
        .push_ready(walk_ready),
        .push_valid(walk_valid),
        .push_byte(walk_byte)
    );

    mqp_queue_ram u_ram (
        .sys_clk(sys_clk),
        .wr_en(do_write),
        .waddr(wr_ptr_q),
        .wdata(wbyte),
        .rd_en(host_pop),
        .raddr(rd_ptr_q),
        .rdata_q(ram_dout)
    );

    // queue pointers and count; reset request clears at once
    always_ff @(posedge sys_clk) begin
        if (!nrst || queue_reset_req) begin
            wr_ptr_q <= 12'h000;
            rd_ptr_q <= 12'h000;
            count_q <= 13'h0000;
        end else begin
            if (do_write) begin
                wr_ptr_q <= wr_ptr_q + 12'h001;
            end
            if (host_pop || overwrite) begin
                rd_ptr_q <= rd_ptr_q + 12'h001;
            end
            count_q <= count_d;
        end
    end

    // reset request holds the queue one cycle later, for as many cycles as the request stays high
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rst_busy_q <= 1'b0;
        end else begin
            rst_busy_q <= queue_reset_req;
        end
    end

    // sticky overrun, a new overflow beats a clear
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            overrun_q <= 1'b0;
        end else if (overflow_evt) begin
            overrun_q <= 1'b1;
        end else if (overrun_clear) begin
            overrun_q <= 1'b0;
        end
    end

    // count snapshot taken by a high byte read
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            snap_q <= 13'h0000;
        end else if (reg_rd && hit_cnt_h) begin
            snap_q <= count_q;
        end
    end

    // power control two
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pwr2_q <= mqp_pkg::PWR2_RST;
        end else if (reg_wr && hit_pwr2) begin
            pwr2_q <= reg_wdata;
        end
    end

    // trims: all eight bits stored, host keeps bit 0 itself
    logic [7:0] trim_or [7];
    assign trim_or[0] = 8'h00;
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_trim
            logic [7:0] sel_val;
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    trim_q[gi] <= (gi % 2 == 1) ? mqp_pkg::TRIM_L_RST : mqp_pkg::TRIM_H_RST;
                end else if (reg_wr && reg_addr == mqp_pkg::OFS_TRIM[gi]) begin
                    trim_q[gi] <= reg_wdata;
                end
            end
            assign sel_val = (rd_addr_q == mqp_pkg::OFS_TRIM[gi]) ? trim_q[gi] : 8'h00;
            assign trim_or[gi+1] = trim_or[gi] | sel_val;
        end
    endgenerate

    // read pipeline: request, stage, answer
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rd_stage_q <= 1'b0;
            rd_pop_q <= 1'b0;
            rd_addr_q <= 8'h00;
        end else begin
            rd_stage_q <= reg_rd;
            rd_pop_q <= host_pop;
            rd_addr_q <= reg_rd ? reg_addr : rd_addr_q;
        end
    end

    logic is_trim;
    logic [7:0] rd_mux;
    assign is_trim = rd_addr_q == mqp_pkg::OFS_TRIM[0] || rd_addr_q == mqp_pkg::OFS_TRIM[1]
        || rd_addr_q == mqp_pkg::OFS_TRIM[2] || rd_addr_q == mqp_pkg::OFS_TRIM[3]
        || rd_addr_q == mqp_pkg::OFS_TRIM[4] || rd_addr_q == mqp_pkg::OFS_TRIM[5];
    assign rd_mux =
        (rd_addr_q == mqp_pkg::OFS_PWR2) ? pwr2_q :
        (rd_addr_q == mqp_pkg::OFS_CNT_H) ? {3'h0, snap_q[12:8]} :
        (rd_addr_q == mqp_pkg::OFS_CNT_L) ? snap_q[7:0] :
        (rd_addr_q == mqp_pkg::OFS_DATA) ? (rd_pop_q ? ram_dout : mqp_pkg::EMPTY_BYTE) :
        (rd_addr_q == mqp_pkg::OFS_ID) ? IDENTITY_VALUE :
        is_trim ? trim_or[6] : mqp_pkg::UNMAPPED_RD;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rd_stage_q ? rd_mux : rdata_q;
            rvalid_q <= rd_stage_q;
        end
    end

    // address-select pin: three stages, accepted when the last two agree
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sel_s0_q <= 1'b0;
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
            bus_addr_q <= mqp_pkg::BUS_ADDR_BASE;
        end else begin
            sel_s0_q <= address_select_pin;
            sel_s1_q <= sel_s0_q;
            sel_s2_q <= sel_s1_q;
            if (sel_s1_q == sel_s2_q) begin
                bus_addr_q <= {mqp_pkg::BUS_ADDR_BASE[6:1], sel_s2_q};
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign queue_lowpower_allow = pwr2_q[mqp_pkg::LP_ALLOW_BIT];
    assign accel_x_off = pwr2_q[mqp_pkg::ACC_X_BIT];
    assign accel_y_off = pwr2_q[mqp_pkg::ACC_Y_BIT];
    assign accel_z_off = pwr2_q[mqp_pkg::ACC_Z_BIT];
    assign gyro_x_off = pwr2_q[mqp_pkg::GYR_X_BIT];
    assign gyro_y_off = pwr2_q[mqp_pkg::GYR_Y_BIT];
    assign gyro_z_off = pwr2_q[mqp_pkg::GYR_Z_BIT];
    assign queue_overrun_flag = overrun_q;
    assign queue_reset_busy = rst_busy_q;
    assign bus_target_addr = bus_addr_q;
    // trims in 0.98 mg steps over plus minus 16g, independent of full scale
    assign accel_x_trim = {trim_q[0], trim_q[1][7:1]};
    assign accel_y_trim = {trim_q[2], trim_q[3][7:1]};
    assign accel_z_trim = {trim_q[4], trim_q[5][7:1]};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_id_req;
        reg_rd && reg_addr == mqp_pkg::OFS_ID;
    endsequence
    sequence s_empty_req;
        reg_rd && hit_data && (empty || !queue_enable) && !queue_reset_req;
    endsequence

    chk_lp_reset_zero: assert property ($rose(nrst) |-> !queue_lowpower_allow)
        else $error("low-power queue allow not zero after reset");
    chk_accel_standby: assert property (reg_wr && hit_pwr2 |=> accel_x_off == $past(reg_wdata[5])
        && accel_y_off == $past(reg_wdata[4]) && accel_z_off == $past(reg_wdata[3]))
        else $error("accel standby bits do not follow the write");
    chk_gyro_standby: assert property (reg_wr && hit_pwr2 |=> gyro_x_off == $past(reg_wdata[2])
        && gyro_y_off == $past(reg_wdata[1]) && gyro_z_off == $past(reg_wdata[0]))
        else $error("gyro standby bits do not follow the write");
    chk_count_snap: assert property (reg_rd && hit_cnt_h |=> snap_q == $past(count_q))
        else $error("high count read did not snapshot the count");
    chk_count_high: assert property (reg_rd && hit_cnt_h ##1 !reg_rd |->
        ##1 reg_rvalid && reg_rdata == {3'h0, $past(count_q[12:8], 2)})
        else $error("high count byte wrong");
    chk_id_value: assert property (s_id_req |-> ##2 reg_rvalid && reg_rdata == IDENTITY_VALUE)
        else $error("identity register returned a wrong code");
    chk_empty_byte: assert property (s_empty_req |-> ##2 reg_rdata == mqp_pkg::EMPTY_BYTE)
        else $error("empty or disabled queue read not 0xff");
    chk_never_ff: assert property (do_write |-> wbyte != mqp_pkg::EMPTY_BYTE)
        else $error("0xff written into the queue");
    chk_count_cap: assert property (count_q <= mqp_pkg::QCAP)
        else $error("byte count passed the capacity");
    chk_pop_step: assert property (host_pop && !push && !queue_reset_req |=>
        count_q == $past(count_q) - 13'h0001)
        else $error("pop did not decrement the count");
    chk_overrun_set: assert property (overflow_evt |=> queue_overrun_flag)
        else $error("overflow did not set the overrun flag");
    chk_overwrite_old: assert property (overwrite && !queue_reset_req |=>
        rd_ptr_q == $past(rd_ptr_q) + 12'h001 && count_q == mqp_pkg::QCAP)
        else $error("overflow did not discard the oldest byte");
    chk_drop_keep: assert property (drop && !queue_reset_req |=>
        wr_ptr_q == $past(wr_ptr_q) && count_q == mqp_pkg::QCAP)
        else $error("stop-on-full let a byte in");
    chk_reset_clear: assert property (queue_reset_req ##1 !queue_reset_req |-> count_q == 13'h0000
        && queue_reset_busy ##1 !queue_reset_busy)
        else $error("queue reset did not clear or self-clear");
    chk_addr_select: assert property (address_select_pin [*4] |=> bus_target_addr == 7'h69)
        else $error("address select high not reflected");
    chk_trim_low: assert property (reg_wr && reg_addr == mqp_pkg::OFS_TRIM[1] |=>
        accel_x_trim[6:0] == $past(reg_wdata[7:1]))
        else $error("x trim low bits misplaced");
    chk_push_count: assert property (host_push && !full && !host_pop && !queue_reset_req |=>
        count_q == $past(count_q) + 13'h0001)
        else $error("data port write did not queue a byte");
endmodule // mqp_regs

// File: tb/mqp_sensor_model.sv
// sensor front end stand-in: output bytes and the sample tick
`timescale 1ns/1ps
module mqp_sensor_model (
    input wire logic sys_clk,
    input wire logic fire,
    output logic sample_tick,
    output logic [8*mqp_pkg::SRC_BYTES-1:0] sensor_bytes
);
    // byte i stands for register 59+i; the last is all ones to hit the clamp
    always_comb begin
        for (int i = 0; i < mqp_pkg::SRC_BYTES; i++) begin
            sensor_bytes[8*(mqp_pkg::SRC_BYTES-1-i) +: 8] = (i == 13) ? 8'hff : 8'h20 + 8'(i);
        end
    end
    initial sample_tick = 1'b0;
    always @(posedge sys_clk) begin
        sample_tick <= fire;
    end
endmodule // mqp_sensor_model

// File: tb/mqp_regs_tb.sv
// self-checking bench of the queue and power register bank
`timescale 1ns/1ps
module mqp_regs_tb;
    logic sys_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, fire = 0, reg_rvalid, sample_tick;
    logic queue_enable = 1, stop_on_full = 0, lp_mode = 0, qrst = 0, oclr = 0, asel = 0;
    logic ovf, busy;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [4:0] src_enable = 5'h1f;
    logic [6:0] pwr, tgt;
    logic [14:0] trim [3];
    logic [8*mqp_pkg::SRC_BYTES-1:0] sensor_bytes;
    int checked = 0, n_mismatch = 0, cycles = 0;

    always #50 sys_clk = ~sys_clk;

    mqp_sensor_model model (.sys_clk(sys_clk), .fire(fire), .sample_tick(sample_tick), .sensor_bytes(sensor_bytes));
    mqp_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_tick(sample_tick),
        .sensor_bytes(sensor_bytes), .src_enable(src_enable), .queue_enable(queue_enable),
        .stop_on_full(stop_on_full), .accel_lowpower_mode(lp_mode), .queue_reset_req(qrst),
        .overrun_clear(oclr), .address_select_pin(asel), .queue_lowpower_allow(pwr[6]),
        .accel_x_off(pwr[5]), .accel_y_off(pwr[4]), .accel_z_off(pwr[3]), .gyro_x_off(pwr[2]),
        .gyro_y_off(pwr[1]), .gyro_z_off(pwr[0]), .queue_overrun_flag(ovf), .queue_reset_busy(busy),
        .bus_target_addr(tgt), .accel_x_trim(trim[0]), .accel_y_trim(trim[1]), .accel_z_trim(trim[2]));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [14:0] seen, input logic [14:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge sys_clk);
        reg_wr = 0;
    endtask

    // answer stands from the first to the second edge after the request edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge sys_clk);
        reg_rd = 0;
        @(negedge sys_clk);
        chk("rvalid", reg_rvalid, 1'b1);
        chk("rdata", reg_rdata, exp);
    endtask

    task automatic cnt(input logic [12:0] n);
        rd(mqp_pkg::OFS_CNT_H, {3'h0, n[12:8]});
        rd(mqp_pkg::OFS_CNT_L, n[7:0]);
    endtask

    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1;
        @(negedge sys_clk);
        s = 0;
    endtask

    task automatic tick();
        pulse(fire);
        repeat (18) @(negedge sys_clk);
    endtask

    task automatic t_reset();
        chk("target", tgt, 7'h68);
        rd(mqp_pkg::OFS_PWR2, 8'h00);
        rd(mqp_pkg::OFS_TRIM[1], 8'h01);
        rd(mqp_pkg::OFS_DATA, 8'hff);
        cnt(13'h0000);
        wr(mqp_pkg::OFS_ID, 8'h33);
        rd(mqp_pkg::OFS_ID, 8'h5a);
        rd(8'h70, 8'h00);
        asel = 1;
        repeat (5) @(negedge sys_clk);
        chk("target", tgt, 7'h69);
        $display("test reset done");
    endtask

    task automatic t_power();
        logic [7:0] v;
        for (int b = 0; b < 8; b++) begin
            if (b == 6) continue;
            v = 8'h01 << b;
            wr(mqp_pkg::OFS_PWR2, v);
            chk("power", pwr, {v[7], v[5:0]});
            rd(mqp_pkg::OFS_PWR2, v);
        end
        wr(mqp_pkg::OFS_PWR2, 8'h00);
        $display("test power done");
    endtask

    task automatic t_trim();
        logic [7:0] hi;
        logic [7:0] lo;
        for (int j = 0; j < 3; j++) begin
            hi = 8'h80 | 8'(j);
            lo = {7'h2a + 7'(j), 1'b1};
            wr(mqp_pkg::OFS_TRIM[2*j], hi);
            rd(mqp_pkg::OFS_TRIM[2*j+1], 8'h01);
            wr(mqp_pkg::OFS_TRIM[2*j+1], lo);
            chk("trim", trim[j], {hi, lo[7:1]});
            rd(mqp_pkg::OFS_TRIM[2*j+1], lo);
        end
        $display("test trim done");
    endtask

    task automatic t_data();
        wr(mqp_pkg::OFS_DATA, 8'h3c);
        wr(mqp_pkg::OFS_DATA, 8'hff);
        cnt(13'h0002);
        rd(mqp_pkg::OFS_DATA, 8'h3c);
        rd(mqp_pkg::OFS_DATA, 8'hfe);
        rd(mqp_pkg::OFS_DATA, 8'hff);
        cnt(13'h0000);
        queue_enable = 0;
        wr(mqp_pkg::OFS_DATA, 8'h11);
        cnt(13'h0000);
        queue_enable = 1;
        wr(mqp_pkg::OFS_DATA, 8'h22);
        queue_enable = 0;
        rd(mqp_pkg::OFS_DATA, 8'hff);
        cnt(13'h0001);
        queue_enable = 1;
        pulse(qrst);
        chk("busy", busy, 1'b1);
        @(negedge sys_clk);
        chk("busy", busy, 1'b0);
        cnt(13'h0000);
        $display("test data done");
    endtask

    task automatic t_push();
        lp_mode = 1;
        tick();
        cnt(13'h0000);
        wr(mqp_pkg::OFS_PWR2, 8'h80);
        tick();
        cnt(13'd14);
        for (int i = 0; i < 14; i++) begin
            rd(mqp_pkg::OFS_DATA, (i == 13) ? 8'hfe : 8'h20 + 8'(i));
        end
        lp_mode = 0;
        src_enable = 5'h12;
        tick();
        cnt(13'h0004);
        rd(mqp_pkg::OFS_DATA, 8'h26);
        rd(mqp_pkg::OFS_DATA, 8'h27);
        rd(mqp_pkg::OFS_DATA, 8'h2c);
        rd(mqp_pkg::OFS_DATA, 8'hfe);
        $display("test push done");
    endtask

    task automatic t_ovf();
        stop_on_full = 1;
        for (int k = 0; k < 4096; k++) begin
            wr(mqp_pkg::OFS_DATA, 8'(k % 128));
        end
        chk("overrun", ovf, 1'b0);
        cnt(13'h1000);
        src_enable = 5'h10;
        tick();
        chk("overrun", ovf, 1'b1);
        cnt(13'h1000);
        rd(mqp_pkg::OFS_DATA, 8'h00);
        pulse(oclr);
        chk("overrun", ovf, 1'b0);
        stop_on_full = 0;
        tick();
        chk("overrun", ovf, 1'b1);
        rd(mqp_pkg::OFS_DATA, 8'h02);
        cnt(13'h0fff);
        $display("test overflow done");
    endtask

    initial begin
        repeat (20) @(negedge sys_clk);
        nrst = 1;
        t_reset();
        t_power();
        t_trim();
        t_data();
        t_push();
        t_ovf();
        tally_and_finish();
    end
endmodule // mqp_regs_tb
